// ==== rtl/packet_buffer_descriptor_walker.sv ====
// Behaviour
// R01 - word zero links to next descriptor
// R02 - software marks first fragment descriptors
// R03 - software marks last fragment descriptors
// R04 - fragments use consecutive descriptors
// R05 - word one holds buffer address
// R06 - offset in upper half, data buffers only
// R07 - length in lower half of word two
// R08 - empty buffer length is capacity, never exceeded
// R09 - flags in word three upper half
// R10 - packet length used only on data first
// R11 - first descriptor carries whole packet length
// R12 - software zeroes final link word
// R13 - owner flag on first; device clears it
// R14 - fetch four consecutive words, then buffer
`include "desc_walk_params.svh"
module packet_buffer_descriptor_walker (
   input wire logic clk_i, // system clock, 20 MHz
   input wire logic rst_i, // synchronous reset, active high
   input wire logic start_i, // pulse: walk the chain at head_addr_i
   input desc_walk_pkg::word_type head_addr_i, // first descriptor address
   input wire logic rx_mode_i, // 1: buffers are empty, to be filled
   output logic mem_req_o, // memory access request, held until ack
   output logic mem_we_o, // 1: write, 0: read
   output desc_walk_pkg::word_type mem_addr_o, // memory byte address
   output desc_walk_pkg::word_type mem_wdata_o, // memory write data
   input wire logic mem_ack_i, // memory access completes
   input desc_walk_pkg::word_type mem_rdata_i, // read data with ack
   output logic buf_req_o, // buffer ready for the data mover
   output desc_walk_pkg::word_type buf_addr_o, // first byte address
   output desc_walk_pkg::half_type buf_len_o, // bytes held or capacity
   output logic buf_first_o, // buffer is a packet's first fragment
   output logic buf_last_o, // buffer is a packet's last fragment
   output desc_walk_pkg::half_type pkt_len_o, // total packet length
   output logic pkt_len_valid_o, // pkt_len_o is meaningful
   input wire logic buf_done_i, // data mover finished the buffer
   input desc_walk_pkg::half_type buf_count_i, // bytes received
   output logic busy_o, // chain walk in progress
   output logic chain_end_o, // pulse: null link reached
   output logic owner_err_o // pulse: first descriptor not owned
);
   import desc_walk_pkg::*;

   function automatic half_type hi_half(input word_type w);
      return w[`HI_MSB:`HI_LSB];
   endfunction : hi_half

   function automatic half_type lo_half(input word_type w);
      return w[`LO_MSB:`LO_LSB];
   endfunction : lo_half

   state_type state_ff;
   logic [1:0] idx_ff;
   word_type base_ff;
   word_type sop_addr_ff;
   word_type sop_flags_ff;
   half_type acc_ff;
   logic rx_ff;
   logic mem_req_ff, mem_we_ff, buf_req_ff, buf_first_ff, buf_last_ff;
   logic pkt_len_valid_ff, busy_ff, chain_end_ff, owner_err_ff;
   word_type mem_addr_ff, mem_wdata_ff, buf_addr_ff;
   half_type buf_len_ff, pkt_len_ff;

   desc_store_if dif ();

   desc_store u_store (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .port(dif.store)
   );

   // R14 capture words
   assign dif.we = (state_ff == ST_FETCH) && mem_ack_i;
   assign dif.idx = idx_ff;
   assign dif.wdata = mem_rdata_i;

   wire word_type link_w = dif.word[`IDX_LINK];
   wire word_type bufp_w = dif.word[`IDX_BUFFER];
   wire half_type off_w = hi_half(dif.word[`IDX_LENGTH]);
   wire half_type len_w = lo_half(dif.word[`IDX_LENGTH]);
   wire word_type flags_w = dif.word[`IDX_FLAGS];
   wire half_type plen_w = lo_half(flags_w);
   wire first_w = flags_w[`FIRST_BIT];
   wire last_w = flags_w[`LAST_BIT];
   wire owner_w = flags_w[`OWNER_BIT];
   // R08 clamp to capacity
   wire half_type clamp_w = (rx_ff && buf_count_i < buf_len_ff) ?
      buf_count_i : buf_len_ff;
   wire half_type acc_sum_w = 16'(acc_ff + clamp_w);
   // R13 owner cleared on writeback
   wire word_type wb_data_w = rx_ff ?
      {hi_half(sop_flags_ff & ~`OWNER_MASK), acc_sum_w} :
      (sop_flags_ff & ~`OWNER_MASK);
   // R06 offset only for data buffers
   wire word_type data_addr_w = rx_ff ? bufp_w :
      word_type'(bufp_w + {`HALF_ZERO, off_w});
   // descriptor ends its walk step either with or without a writeback
   wire adv_w = (state_ff == ST_BUF && buf_done_i && !buf_last_ff) ||
      (state_ff == ST_WBACK && mem_ack_i);
   wire start_w = state_ff == ST_IDLE && start_i &&
      head_addr_i != `NULL_LINK;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff <= ST_IDLE;
         idx_ff <= `IDX_LINK;
         base_ff <= `WORD_ZERO;
         sop_addr_ff <= `WORD_ZERO;
         sop_flags_ff <= `WORD_ZERO;
         acc_ff <= `HALF_ZERO;
         rx_ff <= 1'b0;
         mem_req_ff <= 1'b0;
         mem_we_ff <= 1'b0;
         mem_addr_ff <= `WORD_ZERO;
         mem_wdata_ff <= `WORD_ZERO;
         buf_req_ff <= 1'b0;
         buf_addr_ff <= `WORD_ZERO;
         buf_len_ff <= `HALF_ZERO;
         buf_first_ff <= 1'b0;
         buf_last_ff <= 1'b0;
         pkt_len_ff <= `HALF_ZERO;
         pkt_len_valid_ff <= 1'b0;
         busy_ff <= 1'b0;
         chain_end_ff <= 1'b0;
         owner_err_ff <= 1'b0;
      end else begin
         chain_end_ff <= 1'b0;
         owner_err_ff <= 1'b0;
         if (adv_w) begin
            mem_we_ff <= 1'b0;
            buf_req_ff <= 1'b0;
            pkt_len_valid_ff <= 1'b0;
            // R12 null link ends the walk
            if (link_w == `NULL_LINK) begin
               state_ff <= ST_IDLE;
               mem_req_ff <= 1'b0;
               busy_ff <= 1'b0;
               chain_end_ff <= 1'b1;
            end else begin
               // R01 follow the link
               state_ff <= ST_FETCH;
               base_ff <= link_w;
               idx_ff <= `IDX_LINK;
               mem_req_ff <= 1'b1;
               mem_addr_ff <= link_w;
            end
            if (state_ff == ST_BUF) begin
               acc_ff <= acc_sum_w;
            end
         end else begin
            unique case (state_ff)
               ST_IDLE: begin
                  if (start_w) begin
                     state_ff <= ST_FETCH;
                     busy_ff <= 1'b1;
                     rx_ff <= rx_mode_i;
                     base_ff <= head_addr_i;
                     idx_ff <= `IDX_LINK;
                     mem_req_ff <= 1'b1;
                     mem_we_ff <= 1'b0;
                     mem_addr_ff <= head_addr_i;
                  end
               end
               ST_FETCH: begin
                  // R14 consecutive word reads
                  if (mem_ack_i && idx_ff == `IDX_LAST_WORD) begin
                     mem_req_ff <= 1'b0;
                     state_ff <= ST_CHECK;
                  end else if (mem_ack_i) begin
                     idx_ff <= 2'(idx_ff + 2'h1);
                     mem_addr_ff <= mem_addr_ff + `WORD_STRIDE;
                  end
               end
               ST_CHECK: begin
                  // R13 device must own the packet
                  if (first_w && !owner_w) begin
                     owner_err_ff <= 1'b1;
                     busy_ff <= 1'b0;
                     state_ff <= ST_IDLE;
                  end else begin
                     if (first_w) begin
                        sop_addr_ff <= base_ff;
                        sop_flags_ff <= flags_w;
                        acc_ff <= `HALF_ZERO;
                     end
                     // R05 present the buffer
                     buf_req_ff <= 1'b1;
                     buf_addr_ff <= data_addr_w;
                     // R07 length or capacity
                     buf_len_ff <= len_w;
                     // R09 fragment flags
                     buf_first_ff <= first_w;
                     buf_last_ff <= last_w;
                     // R11 total packet length
                     pkt_len_ff <= plen_w;
                     // R10 packet length on data first only
                     pkt_len_valid_ff <= first_w && !rx_ff;
                     state_ff <= ST_BUF;
                  end
               end
               ST_BUF: begin
                  if (buf_done_i) begin
                     // last fragment: patch the first descriptor
                     buf_req_ff <= 1'b0;
                     pkt_len_valid_ff <= 1'b0;
                     acc_ff <= acc_sum_w;
                     mem_req_ff <= 1'b1;
                     mem_we_ff <= 1'b1;
                     mem_addr_ff <= sop_addr_ff + `FLAGS_WORD_OFS;
                     mem_wdata_ff <= wb_data_w;
                     state_ff <= ST_WBACK;
                  end
               end
               ST_WBACK: begin
                  state_ff <= ST_WBACK;
               end
               default: begin
                  state_ff <= ST_IDLE;
               end
            endcase
         end
      end
   end

   assign mem_req_o = mem_req_ff;
   assign mem_we_o = mem_we_ff;
   assign mem_addr_o = mem_addr_ff;
   assign mem_wdata_o = mem_wdata_ff;
   assign buf_req_o = buf_req_ff;
   assign buf_addr_o = buf_addr_ff;
   assign buf_len_o = buf_len_ff;
   assign buf_first_o = buf_first_ff;
   assign buf_last_o = buf_last_ff;
   assign pkt_len_o = pkt_len_ff;
   assign pkt_len_valid_o = pkt_len_valid_ff;
   assign busy_o = busy_ff;
   assign chain_end_o = chain_end_ff;
   assign owner_err_o = owner_err_ff;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_last_done;
      state_ff == ST_WBACK && mem_ack_i && link_w == `NULL_LINK;
   endsequence
   sequence s_end_pulse;
      chain_end_o && !busy_o ##1 !chain_end_o;
   endsequence

   AST_LINK_FOLLOW: assert property ( // R01
      state_ff == ST_BUF && buf_done_i && !buf_last_ff &&
      link_w != `NULL_LINK |=> mem_req_o && !mem_we_o &&
      mem_addr_o == $past(link_w))
      else $error("link word not followed");
   AST_FETCH_STRIDE: assert property ( // R14
      state_ff == ST_FETCH && mem_ack_i && idx_ff != `IDX_LAST_WORD
      |=> mem_req_o && mem_addr_o == $past(mem_addr_o) + `WORD_STRIDE)
      else $error("descriptor words not consecutive");
   AST_TX_ADDR: assert property ( // R06
      $rose(buf_req_o) && !rx_ff |->
      buf_addr_o == word_type'(bufp_w + {`HALF_ZERO, off_w}))
      else $error("transmit buffer address ignores offset");
   AST_RX_ADDR: assert property ( // R05
      $rose(buf_req_o) && rx_ff |-> buf_addr_o == bufp_w)
      else $error("receive buffer address wrong");
   AST_LEN: assert property ( // R07
      $rose(buf_req_o) |-> buf_len_o == len_w &&
      buf_first_o == first_w && buf_last_o == last_w)
      else $error("buffer length or flags wrong");
   // received count may overshoot; the tally must grow by capacity at most
   AST_CLAMP: assert property ( // R08
      state_ff == ST_BUF && buf_done_i && rx_ff |=>
      16'(acc_ff - $past(acc_ff)) <= $past(buf_len_o))
      else $error("buffer capacity exceeded");
   AST_PKTLEN: assert property ( // R10
      pkt_len_valid_o |-> buf_first_o && !rx_ff &&
      pkt_len_o == plen_w)
      else $error("packet length presented wrongly");
   AST_OWNER_CLEAR: assert property ( // R13
      mem_req_o && mem_we_o |-> !mem_wdata_o[`OWNER_BIT] &&
      mem_addr_o == sop_addr_ff + `FLAGS_WORD_OFS)
      else $error("owner flag not cleared on first descriptor");
   AST_OWNER_ERR: assert property ( // R13
      state_ff == ST_CHECK && first_w && !owner_w |=>
      owner_err_o && !busy_o && !buf_req_o)
      else $error("unowned packet not refused");
   AST_CHAIN_END: assert property ( // R12
      s_last_done |=> s_end_pulse)
      else $error("chain end not signalled");
endmodule : packet_buffer_descriptor_walker

// ==== rtl/desc_walk_params.svh ====
`ifndef DESC_WALK_PARAMS_SVH
`define DESC_WALK_PARAMS_SVH

// descriptor layout, word indices within one descriptor
`define DESC_WORDS 4
`define IDX_LINK 2'h0
`define IDX_BUFFER 2'h1
`define IDX_LENGTH 2'h2
`define IDX_FLAGS 2'h3
`define IDX_LAST_WORD 2'h3
// byte stride between words and byte offset of the flags word
`define WORD_STRIDE 32'h4
`define FLAGS_WORD_OFS 32'hc
`define NULL_LINK 32'h0
// half-word fields
`define HI_MSB 31
`define HI_LSB 16
`define LO_MSB 15
`define LO_LSB 0
// flag bits inside the flags word
`define FIRST_BIT 31
`define LAST_BIT 30
`define OWNER_BIT 29
`define OWNER_MASK 32'h2000_0000
`define HALF_ZERO 16'h0
`define WORD_ZERO 32'h0

`endif

// ==== rtl/desc_walk_pkg.sv ====
package desc_walk_pkg;
   typedef logic [31:0] word_type;
   typedef logic [15:0] half_type;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_FETCH = 3'b001,
      ST_CHECK = 3'b010,
      ST_BUF = 3'b011,
      ST_WBACK = 3'b100
   } state_type;
endpackage : desc_walk_pkg

// ==== rtl/desc_store_if.sv ====
`include "desc_walk_params.svh"
interface desc_store_if;
   import desc_walk_pkg::*;
   logic we;
   logic [1:0] idx;
   word_type wdata;
   word_type word [`DESC_WORDS];
   modport walker (output we, output idx, output wdata, input word);
   modport store (input we, input idx, input wdata, output word);
endinterface : desc_store_if

// ==== rtl/desc_store.sv ====
`include "desc_walk_params.svh"
module desc_store (
   input wire logic clk_i, // system clock
   input wire logic rst_i, // synchronous reset, active high
   desc_store_if.store port // word writes in, held words out
);
   import desc_walk_pkg::*;

   genvar g;
   generate
      for (g = 0; g < `DESC_WORDS; g++) begin : g_word
         word_type word_ff;
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               word_ff <= `WORD_ZERO;
            end else if (port.we && port.idx == 2'(g)) begin
               word_ff <= port.wdata;
            end
         end
         assign port.word[g] = word_ff;
      end
   endgenerate
endmodule : desc_store

// ==== test/sw_mem.sv ====
module sw_mem
   import desc_walk_pkg::*;
(
   input wire logic clk_i, // system clock
   input wire logic req_i, // access request
   input wire logic we_i, // 1: write
   input word_type addr_i, // byte address
   input word_type wdata_i, // write data
   input wire logic [3:0] wait_i, // extra wait cycles
   output logic ack_o, // one-cycle completion
   output word_type rdata_o // read data with ack
);
   timeunit 1ns;
   timeprecision 1ns;
   word_type mem [word_type];
   int writes = 0;
   logic [3:0] cnt_ff = 4'h0;
   initial ack_o = 1'b0;
   initial rdata_o = 32'h0;
   always @(posedge clk_i) begin
      ack_o <= 1'b0;
      // bus not answering never shows a stale word
      rdata_o <= ~rdata_o;
      if (req_i && !ack_o) begin
         if (cnt_ff != wait_i) begin
            cnt_ff <= cnt_ff + 4'h1;
         end else begin
            cnt_ff <= 4'h0;
            ack_o <= 1'b1;
            if (we_i) begin
               mem[addr_i] = wdata_i;
               writes++;
            end else if (mem.exists(addr_i)) begin
               rdata_o <= mem[addr_i];
            end
         end
      end
   end
endmodule : sw_mem

// ==== test/tb_top.sv ====
`include "desc_walk_params.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import desc_walk_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1, start_i = 1'b0, rx_mode_i = 1'b0;
   logic buf_done_i = 1'b0, own_g = 1'b1, big_g = 1'b0;
   logic mem_req_o, mem_we_o, mem_ack_i, buf_req_o, buf_first_o;
   logic buf_last_o, pkt_len_valid_o, busy_o, chain_end_o, owner_err_o;
   word_type head_addr_i = 32'h0, na;
   word_type mem_addr_o, mem_wdata_o, mem_rdata_i, buf_addr_o;
   half_type buf_len_o, pkt_len_o, buf_count_i = 16'h0;
   logic [3:0] wait_g = 4'h0;
   int mismatches = 0, checks = 0;
   typedef struct {word_type a; half_type len; logic f; logic l;
      half_type pl; logic pv; half_type cnt;} exp_type;
   typedef struct {word_type a; word_type w;} wb_type;
   exp_type exp_q[$];
   wb_type wb_q[$];

   always #25 clk_i = ~clk_i;

   packet_buffer_descriptor_walker u_packet_buffer_descriptor_walker (
      .clk_i(clk_i), .rst_i(rst_i), .start_i(start_i),
      .head_addr_i(head_addr_i), .rx_mode_i(rx_mode_i),
      .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
      .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i),
      .mem_rdata_i(mem_rdata_i), .buf_req_o(buf_req_o),
      .buf_addr_o(buf_addr_o), .buf_len_o(buf_len_o),
      .buf_first_o(buf_first_o), .buf_last_o(buf_last_o),
      .pkt_len_o(pkt_len_o), .pkt_len_valid_o(pkt_len_valid_o),
      .buf_done_i(buf_done_i), .buf_count_i(buf_count_i),
      .busy_o(busy_o), .chain_end_o(chain_end_o),
      .owner_err_o(owner_err_o));
   sw_mem u_sw_mem (.clk_i(clk_i), .req_i(mem_req_o), .we_i(mem_we_o),
      .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .wait_i(wait_g),
      .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));

   task automatic chk_w(input word_type got, input word_type exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk_w

   task automatic chk_b(input logic got, input logic exp);
      chk_w({31'h0, got}, {31'h0, exp});
   endtask : chk_b

   task automatic setup(input logic rx, input logic [3:0] wt);
      na = 32'h1000 + (word_type'($urandom_range(0, 255)) << 4);
      head_addr_i = na;
      rx_mode_i = rx;
      wait_g = wt;
      exp_q.delete();
      wb_q.delete();
      u_sw_mem.mem.delete();
      u_sw_mem.writes = 0;
   endtask : setup

   task automatic pkt(input int nf, input logic ends);
      half_type ln[3];
      half_type tot, sum, off;
      word_type w3, w3f, bp, first;
      exp_type e;
      tot = 16'h0;
      sum = 16'h0;
      first = na;
      for (int i = 0; i < nf; i++) begin
         ln[i] = big_g ? 16'hffff : half_type'($urandom_range(1, 600));
         tot += ln[i];
      end
      for (int i = 0; i < nf; i++) begin
         bp = $urandom;
         off = big_g ? 16'hffff : half_type'($urandom);
         w3 = (i == 0) ? {16'h0, tot} : 32'h0;
         w3[`FIRST_BIT] = (i == 0);
         w3[`LAST_BIT] = ends && (i == nf - 1);
         w3[`OWNER_BIT] = own_g && (i == 0);
         if (i == 0) w3f = w3;
         e.cnt = rx_mode_i ? half_type'($urandom_range(0, ln[i] + 20)) : 16'h0;
         sum += (e.cnt < ln[i]) ? e.cnt : ln[i];
         u_sw_mem.mem[na] = na + 32'h10;
         u_sw_mem.mem[na + 32'h4] = bp;
         u_sw_mem.mem[na + 32'h8] = {off, ln[i]};
         u_sw_mem.mem[na + 32'hc] = w3;
         e.a = rx_mode_i ? bp : bp + {16'h0, off};
         e.len = ln[i];
         e.f = (i == 0);
         e.l = w3[`LAST_BIT];
         e.pl = tot;
         e.pv = !rx_mode_i && (i == 0);
         if (own_g) exp_q.push_back(e);
         na += 32'h10;
      end
      if (own_g && ends) wb_q.push_back('{first + 32'hc,
         {w3f[31:30], 1'b0, w3f[28:16], rx_mode_i ? sum : tot}});
   endtask : pkt

   task automatic run(input logic err, input string name);
      int n;
      exp_type e;
      u_sw_mem.mem[na - 32'h10] = 32'h0;
      n = 0;
      start_i = 1'b1;
      @(negedge clk_i);
      start_i = 1'b0;
      while (!chain_end_o && !owner_err_o && n < 2000) begin
         if (buf_req_o) begin
            chk_b(exp_q.size() != 0, 1'b1);
            chk_b(busy_o, 1'b1);
            e = exp_q.pop_front();
            chk_w(buf_addr_o, e.a);
            chk_w({16'h0, buf_len_o}, {16'h0, e.len});
            chk_b(buf_first_o, e.f);
            chk_b(buf_last_o, e.l);
            chk_b(pkt_len_valid_o, e.pv);
            if (e.pv) chk_w({16'h0, pkt_len_o}, {16'h0, e.pl});
            buf_done_i = 1'b1;
            buf_count_i = e.cnt;
         end
         @(negedge clk_i);
         buf_done_i = 1'b0;
         n++;
      end
      chk_b(err ? owner_err_o : chain_end_o, 1'b1);
      chk_w(word_type'(exp_q.size()), 32'h0);
      @(negedge clk_i);
      chk_b(busy_o | chain_end_o | owner_err_o, 1'b0);
      foreach (wb_q[k]) chk_w(u_sw_mem.mem[wb_q[k].a], wb_q[k].w);
      chk_w(word_type'(u_sw_mem.writes), word_type'(wb_q.size()));
      $display("test %s done", name);
   endtask : run

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_of_test

   initial begin
      repeat (40000) @(posedge clk_i);
      mismatches++;
      end_of_test();
   end

   initial begin
      void'($urandom(50));
      repeat (12) @(negedge clk_i);
      rst_i = 1'b0;
      // widest offset and length first, then a three-fragment packet
      setup(1'b0, 4'h0);
      big_g = 1'b1;
      pkt(1, 1'b1);
      big_g = 1'b0;
      pkt(3, 1'b1);
      pkt(1, 1'b1);
      run(1'b0, "tx_chain");
      setup(1'b1, 4'h3);
      pkt(2, 1'b1);
      pkt(1, 1'b1);
      run(1'b0, "rx_slow");
      setup(1'b0, 4'h1);
      own_g = 1'b0;
      pkt(1, 1'b1);
      own_g = 1'b1;
      run(1'b1, "not_owned");
      // null link before the last fragment: no patch expected
      setup(1'b0, 4'h0);
      pkt(2, 1'b0);
      run(1'b0, "cut_chain");
      repeat (12) begin
         setup($urandom_range(0, 1) == 1, 4'($urandom));
         repeat ($urandom_range(1, 3)) pkt($urandom_range(1, 3), 1'b1);
         run(1'b0, "random");
      end
      end_of_test();
   end
endmodule : tb_top
